// ---- inc/mcd_map.svh ----
// Constants of the controller message decoder: offsets, fields, resets, codes.
`ifndef MCD_MAP_SVH
`define MCD_MAP_SVH
// ----------------------------------------
// Controller numbers and parameter codes
// ----------------------------------------
`define MCD_CC_BANK_MSB 7'h00
`define MCD_CC_DATA 7'h06
`define MCD_CC_VOL 7'h07
`define MCD_CC_EXPR 7'h0B
`define MCD_CC_BANK_LSB 7'h20
`define MCD_CC_DATA_LSB 7'h26
`define MCD_CC_SND_FIRST 7'h46
`define MCD_CC_SND_LAST 7'h4F
`define MCD_CC_EFX_A 7'h5C
`define MCD_CC_EFX_B 7'h5E
`define MCD_CC_EFX_C 7'h5F
`define MCD_CC_NRPN_LSB 7'h62
`define MCD_CC_NRPN_MSB 7'h63
`define MCD_CC_RPN_LSB 7'h64
`define MCD_CC_RPN_MSB 7'h65
`define MCD_RPN_BEND 7'h00
`define MCD_RPN_FINE 7'h01
`define MCD_RPN_COARSE 7'h02
`define MCD_NRPN_ARP_SW 7'h02
`define MCD_NRPN_GATE 7'h0A
`define MCD_NRPN_VEL 7'h0B
`define MCD_CENTER 7'h40
`define MCD_BEND_MAX 7'h0C
`define MCD_FINE_MIN 7'h20
`define MCD_FINE_MAX 7'h60
`define MCD_FINE_NUM 12'sd25
`define MCD_FINE_DEN 12'sd16
`define MCD_COARSE_MIN 7'h28
`define MCD_COARSE_MAX 7'h58
`define MCD_VAL_MAX 7'h7F
`define MCD_KNOB_CC_MAX 7'h5F
`define MCD_SND_COUNT 10
// ----------------------------------------
// Register offsets, fields and resets
// ----------------------------------------
`define MCD_REG_CTRL 8'h00
`define MCD_REG_CMD 8'h04
`define MCD_REG_TUNE 8'h08
`define MCD_REG_LEVEL 8'h0C
`define MCD_REG_ARP 8'h10
`define MCD_REG_BANK 8'h14
`define MCD_REG_EDIT 8'h18
`define MCD_REG_EFX 8'h1C
`define MCD_REG_KNOB 8'h20
`define MCD_REG_BASE0 8'h40
`define MCD_CTRL_RST 32'h0064_0000
`define MCD_CMD_STOP 0
`define MCD_CMD_WRITE 1
`define MCD_CTRL_FILT 8
`define MCD_BASE_RST 7'h40
`define MCD_ARP_RST 7'h40
`define MCD_RESP_OK 2'h0
`define MCD_RESP_ERR 2'h2
`endif

// ---- inc/mcd_pkg.sv ----
// Types shared by the controller message decoder.
package mcd_pkg;
	typedef enum logic [2:0] {
		MCD_MODE_PROGRAM,
		MCD_MODE_COMBI,
		MCD_MODE_SEQ,
		MCD_MODE_SONG,
		MCD_MODE_SAMPLING
	} mcd_mode_t;
	typedef enum logic [2:0] {
		MCD_P_BEND,
		MCD_P_FINE,
		MCD_P_COARSE,
		MCD_P_ARP_SW,
		MCD_P_ARP_GATE,
		MCD_P_ARP_VEL
	} mcd_param_t;
endpackage

// ---- hdl/mcd_sel_mem.sv ----
// Per-channel memory of the last parameter selection, registered read.
`timescale 1ns/10ps
module mcd_sel_mem (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        wr_en_in,
	input  wire logic [3:0]  wr_addr_in,
	input  wire logic [15:0] wr_data_in,
	input  wire logic [3:0]  rd_addr_in,
	output logic      [15:0] rd_data_out
);
	logic [15:0] mem [16];

	// Words reset to zero so a channel starts with no selection.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 16; i++) begin
				mem[i] <= 16'h0000;
			end
		end else if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	// Read data come out of a register one cycle after the address.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= 16'h0000;
		end else begin
			rd_data_out <= mem[rd_addr_in];
		end
	end
endmodule

// ---- hdl/mcd_decoder.sv ----
// Control change decoder with parameter selection, levels and an AXI4-Lite slave.
`timescale 1ns/10ps
`include "mcd_map.svh"
module mcd_decoder (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_n_in,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [7:0]        s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	input  wire logic              msg_valid_in,
	output logic                   msg_ready_out,
	input  wire logic [3:0]        msg_chan_in,
	input  wire logic [6:0]        msg_ctrl_in,
	input  wire logic [6:0]        msg_value_in,
	output logic                   param_valid_out,
	output logic [3:0]             param_chan_out,
	output mcd_pkg::mcd_param_t    param_kind_out,
	output logic [7:0]             param_value_out,
	output logic                   edit_valid_out,
	output logic [3:0]             edit_chan_out,
	output logic [3:0]             edit_index_out,
	output logic                   edit_hpf_out,
	output logic [6:0]             edit_value_out,
	output logic                   edit_savable_out,
	output logic                   edit_commit_out,
	output logic [13:0]            level_out,
	input  wire logic              knob_move_in,
	input  wire logic [6:0]        knob_value_in,
	output logic                   tx_valid_out,
	output logic [3:0]             tx_chan_out,
	output logic [6:0]             tx_ctrl_out,
	output logic [6:0]             tx_value_out
);
	import mcd_pkg::*;

	// ----------------------------------------
	// Registers and message stage
	// ----------------------------------------
	logic [31:0] ctrl;
	logic [6:0]  base_q [`MCD_SND_COUNT];
	logic [6:0]  knob_cc, vol_q, exp_q, fine_q, bank_msb, bank_lsb;
	logic [6:0]  arp_gate, arp_vel;
	logic        arp_on, edit_pending;
	logic [2:0]  efx_q;
	logic [7:0]  bend_q, finet_q, coarse_q;
	logic        stage_b;
	logic [3:0]  b_chan;
	logic [6:0]  b_cc, b_val;
	logic [15:0] sel_rd, sel_wr;
	logic        sel_we;
	logic [7:0]  aw_q, ar_a;
	logic [31:0] w_q;
	logic [3:0]  ws_q;
	logic        aw_full, w_full, wr_go, wr_hit;
	logic        cmd_stop, cmd_write;
	mcd_mode_t   mode;
	logic        multi, accept, on_global, is_snd;
	logic [3:0]  snd_idx;

	assign mode = mcd_mode_t'(ctrl[6:4]);
	// Multi-part modes take every channel; the others only the global one.
	assign multi = mode inside {MCD_MODE_COMBI, MCD_MODE_SEQ, MCD_MODE_SONG};
	assign on_global = b_chan == ctrl[3:0];
	assign accept = multi || on_global;
	assign is_snd = b_cc >= `MCD_CC_SND_FIRST && b_cc <= `MCD_CC_SND_LAST;
	assign snd_idx = 4'(b_cc - `MCD_CC_SND_FIRST);
	// One message in flight; the selection read takes a cycle.
	assign msg_ready_out = !stage_b;

	// Message capture, then one decode cycle.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage_b <= 1'b0;
			b_chan <= 4'h0;
			b_cc <= 7'h00;
			b_val <= 7'h00;
		end else begin
			stage_b <= msg_valid_in && !stage_b;
			if (msg_valid_in && !stage_b) begin
				b_chan <= msg_chan_in;
				b_cc <= msg_ctrl_in;
				b_val <= msg_value_in;
			end
		end
	end

	// ----------------------------------------
	// Selection memory
	// ----------------------------------------
	// selection bytes: bit 15 complete, 14 non-registered.
	always_comb begin
		sel_we = stage_b && accept;
		unique case (b_cc)
			`MCD_CC_RPN_MSB: sel_wr = {2'b00, b_val, sel_rd[6:0]};
			`MCD_CC_RPN_LSB: sel_wr = {2'b10, sel_rd[13:7], b_val};
			`MCD_CC_NRPN_MSB: sel_wr = {2'b01, b_val, sel_rd[6:0]};
			`MCD_CC_NRPN_LSB: sel_wr = {2'b11, sel_rd[13:7], b_val};
			default: begin
				sel_wr = sel_rd;
				sel_we = 1'b0;
			end
		endcase
	end

	mcd_sel_mem u_sel (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (sel_we),
		.wr_addr_in (b_chan),
		.wr_data_in (sel_wr),
		.rd_addr_in (msg_chan_in),
		.rd_data_out(sel_rd)
	);

	// ----------------------------------------
	// Data entry routing
	// ----------------------------------------
	logic       rpn_ok, nrpn_ok, dent;
	logic [7:0] off;
	logic signed [11:0] cent_x;
	logic [7:0] cents;
	assign rpn_ok = sel_rd[15] && !sel_rd[14] && sel_rd[13:7] == 7'h00;
	assign nrpn_ok = sel_rd[15] && sel_rd[14] && sel_rd[13:7] == 7'h00;
	assign dent = stage_b && accept && b_cc == `MCD_CC_DATA;
	assign off = {1'b0, b_val} - {1'b0, `MCD_CENTER};
	// one data step is 50/32 cent; signed division keeps both sides symmetric.
	assign cent_x = $signed(off) * `MCD_FINE_NUM;
	assign cents = 8'(cent_x / `MCD_FINE_DEN);

	// coarse data goes to the channel's stored selection.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			param_valid_out <= 1'b0;
			param_chan_out <= 4'h0;
			param_kind_out <= MCD_P_BEND;
			param_value_out <= 8'h00;
		end else begin
			param_valid_out <= 1'b0;
			param_chan_out <= b_chan;
			if (dent && rpn_ok) begin
				unique case (sel_rd[6:0])
					`MCD_RPN_BEND: if (b_val <= `MCD_BEND_MAX) begin
						param_valid_out <= 1'b1;
						param_kind_out <= MCD_P_BEND;
						param_value_out <= {1'b0, b_val};
					end
					`MCD_RPN_FINE: if (b_val >= `MCD_FINE_MIN && b_val <= `MCD_FINE_MAX) begin
						param_valid_out <= 1'b1;
						param_kind_out <= MCD_P_FINE;
						param_value_out <= cents;
					end
					`MCD_RPN_COARSE: if (b_val >= `MCD_COARSE_MIN && b_val <= `MCD_COARSE_MAX) begin
						param_valid_out <= 1'b1;
						param_kind_out <= MCD_P_COARSE;
						param_value_out <= off;
					end
					default: ;
				endcase
			end else if (dent && nrpn_ok) begin
				unique case (sel_rd[6:0])
					`MCD_NRPN_ARP_SW: begin
						param_valid_out <= 1'b1;
						param_kind_out <= MCD_P_ARP_SW;
						param_value_out <= {7'h00, b_val >= `MCD_CENTER};
					end
					`MCD_NRPN_GATE: begin
						param_valid_out <= 1'b1;
						param_kind_out <= MCD_P_ARP_GATE;
						param_value_out <= {1'b0, b_val};
					end
					`MCD_NRPN_VEL: begin
						param_valid_out <= 1'b1;
						param_kind_out <= MCD_P_ARP_VEL;
						param_value_out <= {1'b0, b_val};
					end
					default: ;
				endcase
			end
		end
	end

	// Status copies of the last applied values, shown to software.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bend_q <= 8'h00;
			finet_q <= 8'h00;
			coarse_q <= 8'h00;
			arp_on <= 1'b0;
			arp_gate <= `MCD_ARP_RST;
			arp_vel <= `MCD_ARP_RST;
			fine_q <= 7'h00;
		end else begin
			if (param_valid_out) begin
				unique case (param_kind_out)
					MCD_P_BEND: bend_q <= param_value_out;
					MCD_P_FINE: finet_q <= param_value_out;
					MCD_P_COARSE: coarse_q <= param_value_out;
					MCD_P_ARP_SW: arp_on <= param_value_out[0];
					MCD_P_ARP_GATE: arp_gate <= param_value_out[6:0];
					MCD_P_ARP_VEL: arp_vel <= param_value_out[6:0];
				endcase
			end
			// fine data byte is kept; it carries no weight here.
			if (stage_b && accept && b_cc == `MCD_CC_DATA_LSB) begin
				fine_q <= b_val;
			end
		end
	end

	// ----------------------------------------
	// Levels, bank and effect switches
	// ----------------------------------------
	// volume and expression, reset on stop-and-return in sequencer and song modes only.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			vol_q <= 7'h64;
			exp_q <= `MCD_VAL_MAX;
			level_out <= 14'h0000;
		end else begin
			level_out <= 14'(vol_q * exp_q);
			if (cmd_stop && (mode == MCD_MODE_SEQ || mode == MCD_MODE_SONG)) begin
				vol_q <= ctrl[22:16];
				exp_q <= `MCD_VAL_MAX;
			end else if (stage_b && accept && b_cc == `MCD_CC_VOL) begin
				vol_q <= b_val;
			end else if (stage_b && accept && b_cc == `MCD_CC_EXPR) begin
				exp_q <= b_val;
			end
		end
	end

	// bank bytes, and effect switches on global only.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bank_msb <= 7'h00;
			bank_lsb <= 7'h00;
			efx_q <= 3'h7;
		end else if (stage_b) begin
			if (accept && b_cc == `MCD_CC_BANK_MSB) bank_msb <= b_val;
			if (accept && b_cc == `MCD_CC_BANK_LSB) bank_lsb <= b_val;
			if (on_global && b_cc == `MCD_CC_EFX_A) efx_q[0] <= b_val != 7'h00;
			if (on_global && b_cc == `MCD_CC_EFX_B) efx_q[1] <= b_val != 7'h00;
			if (on_global && b_cc == `MCD_CC_EFX_C) efx_q[2] <= b_val != 7'h00;
		end
	end

	// ----------------------------------------
	// Relative sound edits
	// ----------------------------------------
	// scale from the stored setting toward minimum or maximum.
	function automatic logic [6:0] rel_scale(input logic [6:0] base, input logic [6:0] v);
		logic [13:0] t;
		t = 14'h0000;
		if (v < `MCD_CENTER) begin
			t = ({7'h00, base} * {7'h00, v}) >> 6;
		end else begin
			t = {7'h00, base} + ({7'h00, `MCD_VAL_MAX - base} * {7'h00, v - `MCD_CENTER}) / 14'd63;
		end
		return t[6:0];
	endfunction

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			edit_valid_out <= 1'b0;
			edit_chan_out <= 4'h0;
			edit_index_out <= 4'h0;
			edit_hpf_out <= 1'b0;
			edit_value_out <= 7'h00;
			edit_savable_out <= 1'b1;
			edit_commit_out <= 1'b0;
			edit_pending <= 1'b0;
		end else begin
			edit_savable_out <= !multi;
			edit_valid_out <= stage_b && accept && is_snd;
			edit_commit_out <= cmd_write && !multi && edit_pending;
			if (stage_b && accept && is_snd) begin
				edit_chan_out <= b_chan;
				edit_index_out <= snd_idx;
				edit_hpf_out <= snd_idx == 4'h1 && ctrl[`MCD_CTRL_FILT];
				edit_value_out <= rel_scale(base_q[snd_idx], b_val);
				edit_pending <= !multi;
			end else if (cmd_write || multi) begin
				edit_pending <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Panel knob
	// ----------------------------------------
	// knob sends its bound controller on the global channel.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_valid_out <= 1'b0;
			tx_chan_out <= 4'h0;
			tx_ctrl_out <= 7'h00;
			tx_value_out <= 7'h00;
		end else begin
			tx_valid_out <= knob_move_in;
			if (knob_move_in) begin
				tx_chan_out <= ctrl[3:0];
				tx_ctrl_out <= knob_cc;
				tx_value_out <= knob_value_in;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i]) o[8*i +: 8] = n[8*i +: 8];
		end
		return o;
	endfunction

	logic [31:0] wv;
	assign wv = wmerge(32'h0000_0000, w_q, ws_q);
	assign s_axi_awready = !aw_full;
	assign s_axi_wready = !w_full;
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_a = {s_axi_araddr[7:2], 2'b00};
	assign wr_go = aw_full && w_full && !s_axi_bvalid;
	assign wr_hit = aw_q <= `MCD_REG_KNOB || (aw_q >= `MCD_REG_BASE0 &&
		aw_q < 8'(`MCD_REG_BASE0 + 4 * `MCD_SND_COUNT));
	assign cmd_stop = wr_go && aw_q == `MCD_REG_CMD && ws_q[0] && w_q[`MCD_CMD_STOP];
	assign cmd_write = wr_go && aw_q == `MCD_REG_CMD && ws_q[0] && w_q[`MCD_CMD_WRITE];

	// Address and data are taken in either order; the write lands once both are in.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MCD_RESP_OK;
		end else begin
			if (s_axi_awvalid && !aw_full) begin
				aw_full <= 1'b1;
				aw_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_full) begin
				w_full <= 1'b1;
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `MCD_RESP_OK : `MCD_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software-written registers; knob bindings above 95 are refused.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl <= `MCD_CTRL_RST;
			knob_cc <= 7'h00;
			for (int i = 0; i < `MCD_SND_COUNT; i++) base_q[i] <= `MCD_BASE_RST;
		end else if (wr_go) begin
			if (aw_q == `MCD_REG_CTRL) ctrl <= wmerge(ctrl, w_q, ws_q) & 32'h007F_017F;
			if (aw_q == `MCD_REG_KNOB && ws_q[0] && w_q[6:0] <= `MCD_KNOB_CC_MAX) begin
				knob_cc <= w_q[6:0];
			end
			for (int i = 0; i < `MCD_SND_COUNT; i++) begin
				if (aw_q == 8'(`MCD_REG_BASE0 + 4 * i) && ws_q[0]) base_q[i] <= wv[6:0];
			end
		end
	end

	// Read mux; unmapped offsets answer zero with an error.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `MCD_RESP_OK;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `MCD_RESP_OK;
			unique case (ar_a)
				`MCD_REG_CTRL: s_axi_rdata <= ctrl;
				`MCD_REG_CMD: s_axi_rdata <= 32'h0000_0000;
				`MCD_REG_TUNE: s_axi_rdata <= {1'b0, fine_q, coarse_q, finet_q, bend_q};
				`MCD_REG_LEVEL: s_axi_rdata <= {2'b00, level_out, 2'b00, exp_q, vol_q};
				`MCD_REG_ARP: s_axi_rdata <= {15'h0000, arp_on, 2'b00, arp_vel, arp_gate};
				`MCD_REG_BANK: s_axi_rdata <= {18'h00000, bank_msb, bank_lsb};
				`MCD_REG_EDIT: s_axi_rdata <= {23'h000000, edit_savable_out, edit_pending,
					efx_q, 4'h0} & 32'h0000_0180;
				`MCD_REG_EFX: s_axi_rdata <= {29'h00000000, efx_q};
				`MCD_REG_KNOB: s_axi_rdata <= {25'h0000000, knob_cc};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `MCD_RESP_ERR;
					for (int i = 0; i < `MCD_SND_COUNT; i++) begin
						if (ar_a == 8'(`MCD_REG_BASE0 + 4 * i)) begin
							s_axi_rdata <= {25'h0000000, base_q[i]};
							s_axi_rresp <= `MCD_RESP_OK;
						end
					end
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_gate_sel;
		dent && nrpn_ok && sel_rd[6:0] == `MCD_NRPN_GATE;
	endsequence
	sequence s_bend_sel;
		dent && rpn_ok && sel_rd[6:0] == `MCD_RPN_BEND && b_val <= `MCD_BEND_MAX;
	endsequence
	property p_level;
		$past(rst_n_in) |-> level_out == 14'($past(vol_q) * $past(exp_q));
	endproperty
	a_level: assert property (p_level) else $error("level not vol times exp");
	property p_stop;
		cmd_stop && mode == MCD_MODE_SEQ |=> exp_q == `MCD_VAL_MAX && vol_q == $past(ctrl[22:16]);
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not restore levels");
	property p_bend;
		s_bend_sel |=> param_valid_out && param_kind_out == MCD_P_BEND && param_value_out <= 8'h0C;
	endproperty
	a_bend: assert property (p_bend) else $error("bend entry not applied");
	property p_fine;
		param_valid_out && param_kind_out == MCD_P_FINE |-> $signed(param_value_out) >= -50
			&& $signed(param_value_out) <= 50;
	endproperty
	a_fine: assert property (p_fine) else $error("fine tune out of range");
	property p_coarse;
		param_valid_out && param_kind_out == MCD_P_COARSE |-> $signed(param_value_out) >= -24
			&& $signed(param_value_out) <= 24;
	endproperty
	a_coarse: assert property (p_coarse) else $error("coarse tune out of range");
	property p_gate;
		s_gate_sel |=> param_valid_out && param_kind_out == MCD_P_ARP_GATE
			&& param_value_out[6:0] == $past(b_val);
	endproperty
	a_gate: assert property (p_gate) else $error("gate entry misrouted");
	property p_efx;
		!$stable(efx_q) |-> $past(on_global) && $past(stage_b);
	endproperty
	a_efx: assert property (p_efx) else $error("effect switched off global channel");
	property p_rel_mid;
		stage_b && accept && is_snd && b_val == `MCD_CENTER |=>
			edit_valid_out && edit_value_out == $past(base_q[snd_idx]);
	endproperty
	a_rel_mid: assert property (p_rel_mid) else $error("centre value changed setting");
	property p_knob;
		tx_valid_out |-> tx_ctrl_out <= `MCD_KNOB_CC_MAX;
	endproperty
	a_knob: assert property (p_knob) else $error("knob bound above 95");
endmodule

// ---- bench/mcd_seq_model.sv ----
// Sequencer-side model that offers control change messages one at a time.
`timescale 1ns/10ps
module mcd_seq_model (
	input  wire logic       clk_sys_in,
	input  wire logic       msg_ready_in,
	output logic            msg_valid_out,
	output logic [3:0]      msg_chan_out,
	output logic [6:0]      msg_ctrl_out,
	output logic [6:0]      msg_value_out
);
	// Lines start idle; released lines show the inverse so stale data never matches.
	initial begin
		msg_valid_out = 1'b0;
		msg_chan_out = 4'h0;
		msg_ctrl_out = 7'h00;
		msg_value_out = 7'h00;
	end
	// A message stands until the edge that samples ready high, then one idle edge passes.
	task automatic send(input logic [3:0] c, input logic [6:0] k, input logic [6:0] v);
		msg_valid_out <= 1'b1;
		msg_chan_out <= c;
		msg_ctrl_out <= k;
		msg_value_out <= v;
		@(posedge clk_sys_in);
		while (msg_ready_in !== 1'b1) @(posedge clk_sys_in);
		msg_valid_out <= 1'b0;
		msg_chan_out <= ~c;
		msg_ctrl_out <= ~k;
		msg_value_out <= ~v;
		@(posedge clk_sys_in);
	endtask
endmodule

// ---- bench/mcd_decoder_tb.sv ----
// Self-checking bench of the controller message decoder.
`timescale 1ns/10ps
`define TB_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module mcd_decoder_tb;
	import mcd_pkg::*;
	logic        clk_sys_in, rst_n_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, msg_valid_in, msg_ready_out;
	logic        param_valid_out, edit_valid_out, edit_hpf_out, knob_move_in, tx_valid_out;
	logic        edit_savable_out, edit_commit_out;
	logic [3:0]  tx_chan_out;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, param_value_out;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, seed = 32'h7A29F6E2, r;
	logic [3:0]  s_axi_wstrb, msg_chan_in, param_chan_out, edit_chan_out, edit_index_out;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [6:0]  msg_ctrl_in, msg_value_in, edit_value_out, knob_value_in, tx_ctrl_out, tx_value_out;
	logic [13:0] level_out, lv;
	logic [16:0] got, want;
	logic [16:0] q[$];
	mcd_param_t  param_kind_out;
	int          errors = 0, n_checks = 0, n_commit = 0;
	mcd_decoder dut_u (.clk_sys_in, .rst_n_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .msg_valid_in, .msg_ready_out, .msg_chan_in,
		.msg_ctrl_in, .msg_value_in, .param_valid_out, .param_chan_out, .param_kind_out,
		.param_value_out, .edit_valid_out, .edit_chan_out, .edit_index_out, .edit_hpf_out,
		.edit_value_out, .edit_savable_out, .edit_commit_out, .level_out, .knob_move_in,
		.knob_value_in, .tx_valid_out, .tx_chan_out, .tx_ctrl_out, .tx_value_out);
	mcd_seq_model seq_u (.clk_sys_in, .msg_ready_in(msg_ready_out), .msg_valid_out(msg_valid_in),
		.msg_chan_out(msg_chan_in), .msg_ctrl_out(msg_ctrl_in), .msg_value_out(msg_value_in));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [17:0] pe(logic [3:0] c, mcd_param_t k, logic [7:0] v);
		return {2'h2, c, k, 1'b0, v};
	endfunction
	// Notes the expected result, if any, before the message leaves.
	task automatic m(input logic [3:0] c, input logic [6:0] k, input logic [6:0] v,
		input logic [17:0] e);
		if (e[17]) q.push_back(e[16:0]);
		seq_u.send(c, k, v);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, monitor and watchdog
	// ----------------------------------------
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	// A pulse with no note pending is a mismatch too, so refused messages are checked here.
	always @(posedge clk_sys_in) begin
		if (param_valid_out === 1'b1) got = {1'b0, param_chan_out, param_kind_out, 1'b0,
			param_value_out};
		else got = {1'b1, edit_chan_out, edit_index_out, edit_hpf_out, edit_value_out};
		if ((param_valid_out === 1'b1 || edit_valid_out === 1'b1) && q.size() == 0) q.push_back(~got);
		if (param_valid_out === 1'b1 || edit_valid_out === 1'b1) begin
			want = q.pop_front();
			`TB_CHK(got, want)
		end
	end
	// Program-write pulses are counted so the test can check there was exactly one.
	always @(posedge clk_sys_in) if (edit_commit_out === 1'b1) n_commit++;
	initial begin
		#100000;
		errors++;
		wrap_up();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{rst_n_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, knob_move_in, knob_value_in} = 56'h0;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rd(8'h00);
		`TB_CHK(d, 32'h0064_0000)
		rd(8'hFC);
		`TB_CHK({rs, d}, 34'h2_0000_0000)
		m(4'h0, 7'h65, 7'h00, 18'h0);
		m(4'h0, 7'h64, 7'h00, 18'h0);
		m(4'h0, 7'h06, 7'h0C, pe(4'h0, MCD_P_BEND, 8'h0C));
		m(4'h0, 7'h06, 7'h0D, 18'h0);
		m(4'h3, 7'h4A, 7'h05, 18'h0);
		m(4'h0, 7'h64, 7'h01, 18'h0);
		m(4'h0, 7'h06, 7'h60, pe(4'h0, MCD_P_FINE, 8'h32));
		m(4'h0, 7'h06, 7'h20, pe(4'h0, MCD_P_FINE, 8'hCE));
		m(4'h0, 7'h64, 7'h02, 18'h0);
		m(4'h0, 7'h06, 7'h34, pe(4'h0, MCD_P_COARSE, 8'hF4));
		m(4'h0, 7'h06, 7'h58, pe(4'h0, MCD_P_COARSE, 8'h18));
		r = xs();
		m(4'h0, 7'h63, 7'h00, 18'h0);
		m(4'h0, 7'h62, 7'h02, 18'h0);
		m(4'h0, 7'h06, 7'h3F, pe(4'h0, MCD_P_ARP_SW, 8'h00));
		m(4'h0, 7'h06, 7'h40, pe(4'h0, MCD_P_ARP_SW, 8'h01));
		m(4'h0, 7'h62, 7'h0A, 18'h0);
		m(4'h0, 7'h06, r[6:0], pe(4'h0, MCD_P_ARP_GATE, {1'b0, r[6:0]}));
		m(4'h0, 7'h62, 7'h0B, 18'h0);
		m(4'h0, 7'h06, r[13:7], pe(4'h0, MCD_P_ARP_VEL, {1'b0, r[13:7]}));
		m(4'h0, 7'h4A, 7'h7F, {6'h30, 4'h4, 1'b0, 7'h7F});
		m(4'h0, 7'h4A, 7'h00, {6'h30, 4'h4, 1'b0, 7'h00});
		wr(8'h00, 32'h0064_0100);
		m(4'h0, 7'h47, 7'h40, {6'h30, 4'h1, 1'b1, 7'h40});
		rd(8'h18);
		`TB_CHK(d, 32'h0000_0180)
		wr(8'h04, 32'h0000_0002);
		rd(8'h18);
		`TB_CHK({edit_savable_out, d}, 33'h1_0000_0100)
		`TB_CHK(n_commit, 1)
		$display("test selection and edits done");
		m(4'h0, 7'h07, r[20:14], 18'h0);
		m(4'h0, 7'h0B, r[27:21], 18'h0);
		m(4'h0, 7'h00, 7'h15, 18'h0);
		m(4'h0, 7'h20, 7'h2A, 18'h0);
		lv = r[20:14] * r[27:21];
		rd(8'h0C);
		`TB_CHK(d, {2'h0, lv, 2'h0, r[27:21], r[20:14]})
		rd(8'h14);
		`TB_CHK(d, 32'h0000_0AAA)
		wr(8'h00, 32'h0064_0020);
		wr(8'h04, 32'h0000_0001);
		rd(8'h0C);
		`TB_CHK(d, 32'h319C_3FE4)
		rd(8'h18);
		`TB_CHK(d, 32'h0000_0000)
		m(4'h1, 7'h65, 7'h00, 18'h0);
		m(4'h1, 7'h64, 7'h00, 18'h0);
		m(4'h2, 7'h65, 7'h00, 18'h0);
		m(4'h2, 7'h64, 7'h01, 18'h0);
		m(4'h1, 7'h06, 7'h05, pe(4'h1, MCD_P_BEND, 8'h05));
		m(4'h2, 7'h06, 7'h40, pe(4'h2, MCD_P_FINE, 8'h00));
		// effect switches, then a refused knob binding and an accepted one.
		m(4'h5, 7'h5C, 7'h00, 18'h0);
		m(4'h0, 7'h5E, 7'h00, 18'h0);
		rd(8'h1C);
		`TB_CHK(d, 32'h0000_0005)
		wr(8'h20, 32'h0000_0060);
		rd(8'h20);
		`TB_CHK(d, 32'h0000_0000)
		wr(8'h20, 32'h0000_004A);
		knob_move_in <= 1'b1;
		knob_value_in <= r[6:0];
		@(posedge clk_sys_in);
		knob_move_in <= 1'b0;
		@(posedge clk_sys_in);
		`TB_CHK({tx_valid_out, tx_chan_out, tx_ctrl_out}, 12'h84A)
		`TB_CHK(tx_value_out, r[6:0])
		repeat (4) @(posedge clk_sys_in);
		`TB_CHK(q.size(), 0)
		$display("test levels and channels done");
		wrap_up();
	end
endmodule
